// >>> dcp_crc8.sv
// Shared constants and types for the chain packet field logic, plus the packet check accumulator
`timescale 1ns/100ps

package dcp_pkg;

	// Command bytes
	localparam logic [7:0] CMD_ADDR_ASSIGN = 8'h57;    // chain_address_assign
	localparam logic [7:0] CMD_WRITE_BC    = 8'h02;    // chain_write_broadcast
	localparam logic [7:0] CMD_READ_BC     = 8'h03;    // chain_read_broadcast
	localparam logic [2:0] CMD_WRITE_SG    = 3'h4;     // chain_write_single, low bits
	localparam logic [2:0] CMD_READ_SG     = 3'h5;     // chain_read_single, low bits

	// Byte positions inside a packet, counted from the command byte
	localparam logic [7:0] IDX_CMD     = 8'h00;        // Command byte
	localparam logic [7:0] IDX_REG     = 8'h01;        // Register address byte
	localparam logic [7:0] IDX_FILL_LO = 8'h02;        // First fill byte, also assigned address
	localparam logic [7:0] IDX_FILL_HI = 8'h03;        // Second fill byte
	localparam logic [7:0] IDX_WR_PEC  = 8'h04;        // Packet check byte of a write
	localparam logic [7:0] IDX_RS_DC   = 8'h04;        // Summary byte of a single read

	// Register offsets on the software port
	localparam logic [3:0] REG_CONFIG  = 4'h0;         // device_config_one
	localparam logic [3:0] REG_ADDRESS = 4'h1;         // Device and first address
	localparam logic [3:0] REG_STATUS  = 4'h2;         // Alert status

	// Field positions
	localparam int CFG_ALIVE_BIT  = 0;                 // alive_count_enable
	localparam int CFG_UNLOCK_BIT = 1;                 // addr_rewrite_unlock
	localparam int ADR_FIRST_LSB  = 8;                 // first_addr_field low bit
	localparam int STS_PEC_BIT    = 0;                 // packet_check_alert
	localparam int SUM_PEC_BIT    = 7;                 // Summary: packet check alert
	localparam int SUM_DIAG_BIT   = 6;                 // Summary: safety diagnostics
	localparam int SUM_OTHER_BIT  = 5;                 // Summary: any other status alert
	localparam int SUM_OV_BIT     = 2;                 // Summary: overvoltage
	localparam int SUM_UV_BIT     = 1;                 // Summary: undervoltage

	// Reset values
	localparam logic       RST_ALIVE_EN  = 1'b0;       // Alive counting off
	localparam logic       RST_UNLOCK    = 1'b1;       // Addresses may be assigned after reset
	localparam logic [4:0] RST_ADDR      = 5'h00;      // Device and first address
	localparam logic [7:0] CRC_INIT      = 8'h00;      // Packet check seed
	localparam logic [7:0] CRC_POLY      = 8'h07;      // Packet check polynomial

	// Packet kinds, one-hot
	typedef enum logic [6:0] {
		KIND_IDLE     = 7'b0000001,
		KIND_PASS     = 7'b0000010,
		KIND_ASSIGN   = 7'b0000100,
		KIND_WRITE_BC = 7'b0001000,
		KIND_WRITE_SG = 7'b0010000,
		KIND_READ_BC  = 7'b0100000,
		KIND_READ_SG  = 7'b1000000
	} dcp_kind_t;

	// One byte step of the packet check, most significant bit first
	function automatic logic [7:0] crc8Step(input logic [7:0] crc, input logic [7:0] data, input logic [7:0] poly);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ poly) : (c << 1);
		end
		return c;
	endfunction : crc8Step

endpackage : dcp_pkg

// Running packet check over a byte stream, restarted by clr
module dcp_crc8 #(
	parameter logic [7:0] POLY = dcp_pkg::CRC_POLY
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       clr,
	input  wire logic       en,
	input  wire logic [7:0] dataByte,
	output logic [7:0]      crcQ
);
	import dcp_pkg::*;

	// Restart takes the first byte at once so the command byte is covered
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			crcQ <= CRC_INIT;
		end else if (clr) begin
			crcQ <= en ? crc8Step(CRC_INIT, dataByte, POLY) : CRC_INIT;
		end else if (en) begin
			crcQ <= crc8Step(crcQ, dataByte, POLY);
		end
	end

endmodule : dcp_crc8

// >>> dcp_packet_fields.sv
// Per-device packet field processing for the daisy-chained battery monitor link
// Operation
// - Summary byte in reads; single read: addressed only
// - OR own status into incoming summary byte
// - Check mismatch sets alert; summary bits 7, 5
// - Summary bits 6, 2, 1, 5 map alerts
// - Check bits 4, 3, 0 forwarded unchanged
// - Write happens only when packet check matches
// - Reads carry recomputed check over transmitted bytes
// - Alive counter follows check when enabled
// - Broadcast: all increment; single: addressed increments
// - Alive counter wraps FFh to 00h
// - Check excludes alive; mismatch still increments
// - Read broadcast: own data right after register address
// - Assignment stores address, forwards it plus one
// - Downstack path forwards assignment unchanged
// - Assignment clears unlock; locked ignores assignment
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/100ps

module dcp_packet_fields (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// Received byte stream from the lower neighbour
	input  wire logic        rxValid,
	input  wire logic        rxFirst,
	input  wire logic [7:0]  rxByte,
	input  wire logic        rxStop,
	input  wire logic        upstackPath,
	// Forwarded byte stream to the next neighbour
	output logic             txValid,
	output logic             txFirst,
	output logic [7:0]       txByte,
	output logic             txStop,
	// Status alert levels from the monitor core
	input  wire logic        safetyDiagAlertOne,
	input  wire logic        safetyDiagAlertTwo,
	input  wire logic        overvoltageAlert,
	input  wire logic        undervoltageAlert,
	input  wire logic        otherStatusAlert,
	// Internal register file access for read and write commands
	output logic [7:0]       regSelAddr,
	input  wire logic [15:0] regRdData,
	output logic             regWrStrobe,
	output logic [7:0]       regWrAddr,
	output logic [15:0]      regWrData,
	// Software register port
	input  wire logic [3:0]  swAddr,
	input  wire logic [15:0] swWrData,
	input  wire logic        swWr,
	input  wire logic        swRd,
	output logic [15:0]      swRdData,
	output logic             packetCheckAlert
);
	import dcp_pkg::*;

	dcp_kind_t   kind_q;                 // Kind of the packet in flight
	logic [7:0]  idx_q;                  // Index of the next received byte
	logic [7:0]  regAddr_q;              // Captured register address byte
	logic [7:0]  wrLsb_q;                // Captured write data low byte
	logic [7:0]  wrMsb_q;                // Captured write data high byte
	logic [7:0]  buf0_q;                 // Oldest delayed byte of a broadcast read
	logic [7:0]  buf1_q;                 // Newest delayed byte
	logic        bufPec0_q;              // Oldest delayed byte is the packet check slot
	logic        bufPec1_q;              // Newest delayed byte is the packet check slot
	logic        aliveEn_q;              // alive_count_enable
	logic        unlock_q;               // addr_rewrite_unlock
	logic [4:0]  devAddr_q;              // device_addr_field
	logic [4:0]  firstAddr_q;            // first_addr_field
	logic        pecAlert_q;             // packet_check_alert, sticky
	logic        txValid_q;
	logic        txFirst_q;
	logic [7:0]  txByte_q;
	logic        txStop_q;
	logic        regWrStrobe_q;
	logic [15:0] swRdData_q;

	dcp_kind_t   kindNow;                // Kind valid in the current byte's cycle
	logic [7:0]  curIdx;                 // Index of the current byte
	logic [4:0]  chainPos;               // Devices below this one
	logic [7:0]  dcIdx;                  // Received summary byte position
	logic [7:0]  pecIdx;                 // Received packet check position
	logic [7:0]  aliveIdx;               // Received alive counter position
	logic        isRead;
	logic        isWrite;
	logic        roleDc;
	logic        rolePec;
	logic        roleAlive;
	logic [7:0]  ownSummary;             // This device's summary contribution
	logic [7:0]  procByte;               // Current byte after field edits
	logic [7:0]  txByte_d;               // Byte emitted this cycle
	logic        txCrcEn;                // Emitted byte is covered by the check
	logic [7:0]  crcRxQ;                 // Check over received bytes so far
	logic [7:0]  crcTxQ;                 // Check over emitted bytes so far
	logic        pecMatch;
	logic        pecMismatch;
	logic        assignTake;             // Valid address assignment this cycle
	logic        cfgWrite;

	// Classify a command byte from the viewpoint of this device
	function automatic dcp_kind_t decodeKind(input logic [7:0] cmd, input logic [4:0] da, input logic up);
		dcp_kind_t k;
		k = KIND_PASS;
		if (!up) begin
			k = KIND_PASS;
		end else if (cmd == CMD_ADDR_ASSIGN) begin
			k = KIND_ASSIGN;
		end else if (cmd == CMD_WRITE_BC) begin
			k = KIND_WRITE_BC;
		end else if (cmd == CMD_READ_BC) begin
			k = KIND_READ_BC;
		end else if (cmd[2:0] == CMD_WRITE_SG && cmd[7:3] == da) begin
			k = KIND_WRITE_SG;
		end else if (cmd[2:0] == CMD_READ_SG && cmd[7:3] == da) begin
			k = KIND_READ_SG;
		end
		return k;
	endfunction : decodeKind

	// Byte position and packet kind of the current byte
	always_comb begin
		curIdx  = rxFirst ? IDX_CMD : idx_q;
		kindNow = rxFirst ? decodeKind(rxByte, devAddr_q, upstackPath) : kind_q;
	end

	// Field positions; a broadcast read grows by one pair per lower device
	always_comb begin
		chainPos = 5'(devAddr_q - firstAddr_q);
		isRead   = (kindNow == KIND_READ_BC) || (kindNow == KIND_READ_SG);
		isWrite  = (kindNow == KIND_WRITE_BC) || (kindNow == KIND_WRITE_SG);
		dcIdx    = (kindNow == KIND_READ_BC) ? 8'(IDX_FILL_LO + {2'h0, chainPos, 1'b0}) : IDX_RS_DC;
		pecIdx   = isWrite ? IDX_WR_PEC : 8'(dcIdx + 8'h01);
		aliveIdx = 8'(pecIdx + 8'h01);
		roleDc    = isRead && (curIdx == dcIdx);
		rolePec   = (isRead || isWrite) && (curIdx == pecIdx);
		roleAlive = (isRead || isWrite) && aliveEn_q && (curIdx == aliveIdx);
	end

	// Own summary bits; the check bits stay zero so received values pass
	always_comb begin
		ownSummary = 8'h00;
		ownSummary[SUM_PEC_BIT]   = pecAlert_q;
		ownSummary[SUM_DIAG_BIT]  = safetyDiagAlertOne | safetyDiagAlertTwo;
		ownSummary[SUM_OTHER_BIT] = otherStatusAlert | pecAlert_q;
		ownSummary[SUM_OV_BIT]    = overvoltageAlert;
		ownSummary[SUM_UV_BIT]    = undervoltageAlert;
	end

	// Edit the current byte according to its role
	always_comb begin
		procByte = rxByte;
		if (roleDc) begin
			procByte = rxByte | ownSummary;
		end else if (roleAlive) begin
			procByte = 8'(rxByte + 8'h01);
		end else if (kindNow == KIND_READ_SG && curIdx == IDX_FILL_LO) begin
			procByte = regRdData[7:0];
		end else if (kindNow == KIND_READ_SG && curIdx == IDX_FILL_HI) begin
			procByte = regRdData[15:8];
		end else if (assignTake) begin
			procByte = {rxByte[7:5], 5'(rxByte[4:0] + 5'h01)};
		end
	end

	// Choose the emitted byte; a broadcast read runs two bytes late after its own data
	always_comb begin
		txByte_d = procByte;
		txCrcEn  = 1'b0;
		if (kindNow == KIND_READ_BC) begin
			if (curIdx == IDX_FILL_LO) begin
				txByte_d = regRdData[7:0];
			end else if (curIdx == IDX_FILL_HI) begin
				txByte_d = regRdData[15:8];
			end else if (curIdx > IDX_FILL_HI) begin
				txByte_d = bufPec0_q ? crcTxQ : buf0_q;
			end
			txCrcEn = (curIdx < 8'(pecIdx + 8'h02));
		end else if (kindNow == KIND_READ_SG) begin
			txByte_d = rolePec ? crcTxQ : procByte;
			txCrcEn  = (curIdx < pecIdx);
		end
	end

	// Check comparison on the received packet check slot
	always_comb begin
		pecMatch    = rxValid && rolePec && (rxByte == crcRxQ);
		pecMismatch = rxValid && rolePec && (rxByte != crcRxQ);
		assignTake  = rxValid && (kindNow == KIND_ASSIGN) && (curIdx == IDX_FILL_LO)
			&& unlock_q && (regAddr_q == 8'h00);
		cfgWrite    = swWr && (swAddr == REG_CONFIG);
	end

	// Check over received bytes, alive counter left out
	dcp_crc8 #(
		.POLY     (CRC_POLY)
	) uRxCrc (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.clr      (rxValid && rxFirst),
		.en       (rxValid && (curIdx < pecIdx)),
		.dataByte (rxByte),
		.crcQ     (crcRxQ)
	);

	// Check over the bytes this device actually sends on
	dcp_crc8 #(
		.POLY     (CRC_POLY)
	) uTxCrc (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.clr      (rxValid && rxFirst),
		.en       (rxValid && (rxFirst || txCrcEn)),
		.dataByte (txByte_d),
		.crcQ     (crcTxQ)
	);

	// Packet tracking: kind and byte position
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			kind_q <= KIND_IDLE;
			idx_q  <= 8'h00;
		end else if (rxStop) begin
			kind_q <= KIND_IDLE;
			idx_q  <= 8'h00;
		end else if (rxValid) begin
			kind_q <= kindNow;
			idx_q  <= (curIdx == 8'hFF) ? curIdx : 8'(curIdx + 8'h01);     // Saturates on runaway frames
		end
	end

	// Two-byte delay line; the last pair at stop is dropped, shrinking the fill area
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			buf0_q    <= 8'h00;
			buf1_q    <= 8'h00;
			bufPec0_q <= 1'b0;
			bufPec1_q <= 1'b0;
		end else if (rxValid) begin
			buf0_q    <= buf1_q;
			buf1_q    <= procByte;
			bufPec0_q <= bufPec1_q;
			bufPec1_q <= rolePec;
		end
	end

	// Forwarded stream, one cycle behind the received one
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			txValid_q <= 1'b0;
			txFirst_q <= 1'b0;
			txByte_q  <= 8'h00;
			txStop_q  <= 1'b0;
		end else begin
			txValid_q <= rxValid;
			txFirst_q <= rxValid && rxFirst;
			txStop_q  <= rxStop;
			if (rxValid) begin
				txByte_q <= txByte_d;
			end
		end
	end

	// Capture register address and write data; write only on a matching check
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			regAddr_q     <= 8'h00;
			wrLsb_q       <= 8'h00;
			wrMsb_q       <= 8'h00;
			regWrStrobe_q <= 1'b0;
		end else begin
			regWrStrobe_q <= rxValid && isWrite && pecMatch;
			if (rxValid && curIdx == IDX_REG) begin
				regAddr_q <= rxByte;
			end
			if (rxValid && isWrite && curIdx == IDX_FILL_LO) begin
				wrLsb_q <= rxByte;
			end
			if (rxValid && isWrite && curIdx == IDX_FILL_HI) begin
				wrMsb_q <= rxByte;
			end
		end
	end

	// Sticky check alert; a new mismatch beats a software clear
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pecAlert_q <= 1'b0;
		end else if (pecMismatch) begin
			pecAlert_q <= 1'b1;
		end else if (swWr && swAddr == REG_STATUS && swWrData[STS_PEC_BIT]) begin
			pecAlert_q <= 1'b0;
		end
	end

	// Configuration; a software unlock in the same cycle beats the hardware lock
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			aliveEn_q <= RST_ALIVE_EN;
			unlock_q  <= RST_UNLOCK;
		end else if (cfgWrite) begin
			aliveEn_q <= swWrData[CFG_ALIVE_BIT];
			unlock_q  <= swWrData[CFG_UNLOCK_BIT];
		end else if (assignTake) begin
			unlock_q  <= 1'b0;
		end
	end

	// Addresses: own address from assignment, first address from software
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			devAddr_q   <= RST_ADDR;
			firstAddr_q <= RST_ADDR;
		end else begin
			if (assignTake) begin
				devAddr_q <= rxByte[4:0];
			end
			if (swWr && swAddr == REG_ADDRESS) begin
				firstAddr_q <= swWrData[ADR_FIRST_LSB +: 5];
			end
		end
	end

	// Software read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			swRdData_q <= 16'h0000;
		end else if (swRd) begin
			case (swAddr)
				REG_CONFIG: begin
					swRdData_q <= {14'h0000, unlock_q, aliveEn_q};
				end
				REG_ADDRESS: begin
					swRdData_q <= {3'h0, firstAddr_q, 3'h0, devAddr_q};
				end
				REG_STATUS: begin
					swRdData_q <= {10'h000, otherStatusAlert, undervoltageAlert, overvoltageAlert,
						safetyDiagAlertTwo, safetyDiagAlertOne, pecAlert_q};
				end
				default: begin
					swRdData_q <= 16'h0000;
				end
			endcase
		end else begin
			swRdData_q <= 16'h0000;
		end
	end

	// Outputs
	assign txValid          = txValid_q;
	assign txFirst          = txFirst_q;
	assign txByte           = txByte_q;
	assign txStop           = txStop_q;
	assign regSelAddr       = regAddr_q;
	assign regWrStrobe      = regWrStrobe_q;
	assign regWrAddr        = regAddr_q;
	assign regWrData        = {wrMsb_q, wrLsb_q};
	assign swRdData         = swRdData_q;
	assign packetCheckAlert = pecAlert_q;

	// Every received byte leaves one cycle later
	stream_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		rxValid |=> txValid_q) else $error("received byte not forwarded");

	// A write strobe needs a matching packet check one cycle before
	write_on_match_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		regWrStrobe_q |-> $past(rxValid && rolePec && isWrite && rxByte == crcRxQ))
		else $error("write without matching check");

	// Alive counter wraps to zero in place
	alive_wrap_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		rxValid && roleAlive && kindNow != KIND_READ_BC && rxByte == 8'hFF |=> txByte_q == 8'h00)
		else $error("alive counter did not wrap");

	// Check bits of the summary pass untouched
	check_bits_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		rxValid && roleDc && kindNow == KIND_READ_SG
		|=> txByte_q[4] == $past(rxByte[4]) && txByte_q[3] == $past(rxByte[3]) && txByte_q[0] == $past(rxByte[0]))
		else $error("summary check bits altered");

	// A mismatch raises the alert and it shows in the summary
	pec_alert_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		pecMismatch |=> pecAlert_q && ownSummary[SUM_PEC_BIT] && ownSummary[SUM_OTHER_BIT])
		else $error("check alert not raised");

	// Assignment locks further assignments
	assign_lock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		assignTake && !cfgWrite |=> !unlock_q ##1 !assignTake)
		else $error("assignment left unlocked");

	// Assignment forwards the address plus one and keeps it
	assign_incr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		assignTake |=> txByte_q[4:0] == 5'($past(rxByte[4:0]) + 5'h01) && devAddr_q == $past(rxByte[4:0]))
		else $error("assigned address not forwarded plus one");

	// Return path forwards bytes unchanged
	downstack_pass_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		rxValid && rxFirst && !upstackPath ##1 (rxValid && !rxFirst) |=> txByte_q == $past(rxByte))
		else $error("return path altered a byte");

	// Broadcast read places own data right after the register address
	own_data_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		rxValid && kindNow == KIND_READ_BC && curIdx == IDX_FILL_LO
		##1 (rxValid && kindNow == KIND_READ_BC && curIdx == IDX_FILL_HI)
		|=> txByte_q == $past(regRdData[15:8]) && $past(txByte_q) == $past(regRdData[7:0], 2))
		else $error("own read data misplaced");

endmodule : dcp_packet_fields

// >>> dcp_host_model.sv
// Host model: sends framed command packets upstack into the device
`timescale 1ns/100ps

module dcp_host_model (
	input  wire logic ref_clk,
	output logic      rxValid,
	output logic      rxFirst,
	output logic [7:0] rxByte,
	output logic      rxStop
);
	// Idle line before the first packet
	initial begin
		rxValid = 1'b0;
		rxFirst = 1'b0;
		rxByte  = 8'h00;
		rxStop  = 1'b0;
	end

	// Packet check, MSB first, seed 00h, polynomial 07h
	function automatic logic [7:0] crc8(input logic [7:0] b[$]);
		logic [7:0] c;
		c = 8'h00;
		foreach (b[i]) begin
			c = c ^ b[i];
			for (int k = 0; k < 8; k++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
		end
		return c;
	endfunction : crc8

	// Bytes back to back, then check, alive and stop
	task automatic sendPkt(input logic [7:0] b[$], input logic withCrc, input logic [7:0] flip,
		input logic withAlive, input logic [7:0] alive);
		logic [7:0] q[$];
		q = b;
		// Flip mask lets a scenario corrupt the check on purpose
		if (withCrc) q.push_back(crc8(b) ^ flip);
		// Alive byte after the check
		if (withAlive) q.push_back(alive);
		foreach (q[i]) begin
			@(posedge ref_clk);
			rxValid <= 1'b1;
			rxFirst <= (i == 0);
			rxByte  <= q[i];
		end
		@(posedge ref_clk);
		rxValid <= 1'b0;
		rxFirst <= 1'b0;
		rxStop  <= 1'b1;
		// Stale byte inverted so nothing leans on a held value
		rxByte  <= ~rxByte;
		@(posedge ref_clk);
		rxStop  <= 1'b0;
	endtask : sendPkt
endmodule : dcp_host_model

// >>> tb_top.sv
// Testbench: packets and register accesses into the packet field block
`timescale 1ns/100ps

module tb_top;
	import dcp_pkg::*;
	logic        ref_clk, nrst, upstackPath, ovAlert, swWr, swRd, stopSeen, diagOne, diagTwo, uvAlert, otherAlert;
	logic        rxValid, rxFirst, rxStop, txValid, txFirst, txStop, regWrStrobe, pcAlert;
	logic [3:0]  swAddr;
	logic [7:0]  rxByte, txByte, regSelAddr, regWrAddr, wrAddr, c;
	logic [15:0] swWrData, swRdData, regWrData, wrWord, d, firstMap;
	logic [7:0]  txQ[$];
	int          wrCnt, errorCnt, samplesChecked;

	dcp_host_model host (.ref_clk(ref_clk), .rxValid(rxValid), .rxFirst(rxFirst), .rxByte(rxByte), .rxStop(rxStop));

	dcp_packet_fields dut (.ref_clk(ref_clk), .nrst(nrst), .rxValid(rxValid), .rxFirst(rxFirst), .rxByte(rxByte),
		.rxStop(rxStop), .upstackPath(upstackPath), .txValid(txValid), .txFirst(txFirst), .txByte(txByte),
		.txStop(txStop), .safetyDiagAlertOne(diagOne), .safetyDiagAlertTwo(diagTwo), .overvoltageAlert(ovAlert),
		.undervoltageAlert(uvAlert), .otherStatusAlert(otherAlert), .regSelAddr(regSelAddr), .regRdData(16'hBEEF),
		.regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr), .regWrData(regWrData), .swAddr(swAddr),
		.swWrData(swWrData), .swWr(swWr), .swRd(swRd), .swRdData(swRdData), .packetCheckAlert(pcAlert));

	// Clock at 100 MHz
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Collects forwarded bytes, stops and internal writes
	always @(posedge ref_clk) begin
		if (txValid === 1'b1) begin
			firstMap[txQ.size()] = txFirst;
			txQ.push_back(txByte);
		end
		if (txStop === 1'b1) stopSeen = 1'b1;
		if (regWrStrobe === 1'b1) begin
			wrCnt++;
			wrWord = regWrData;
			wrAddr = regWrAddr;
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic printVerdict();
		$display("Checks %0d, errors %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : printVerdict

	// One packet through, bounded wait for its stop
	task automatic runPkt(input logic [7:0] b[$], input logic wc, input logic [7:0] f, input logic wa, input logic [7:0] a);
		txQ.delete();
		firstMap = 16'h0000;
		stopSeen = 1'b0;
		host.sendPkt(b, wc, f, wa, a);
		for (int n = 0; n < 20 && !stopSeen; n++) @(posedge ref_clk);
		if (!stopSeen) begin
			errorCnt++;
			printVerdict();
		end
	endtask : runPkt

	task automatic chkPkt(input logic [7:0] e[$]);
		chk(16'(txQ.size()), 16'(e.size()));
		chk(firstMap, 16'h0001);
		foreach (e[i]) if (i < txQ.size()) chk({8'h00, txQ[i]}, {8'h00, e[i]});
	endtask : chkPkt

	task automatic swWrite(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		swWr     <= 1'b1;
		swAddr   <= a;
		swWrData <= v;
		@(posedge ref_clk);
		swWr     <= 1'b0;
	endtask : swWrite

	// Data stands in the cycle after the strobe
	task automatic swRead(input logic [3:0] a);
		@(posedge ref_clk);
		swRd   <= 1'b1;
		swAddr <= a;
		@(posedge ref_clk);
		swRd   <= 1'b0;
		#1 d = swRdData;
	endtask : swRead

	// Assignment, then locked and downstack packets pass untouched
	task automatic tAssign();
		runPkt('{8'h57, 8'h00, 8'h05}, 0, 0, 0, 0);
		chkPkt('{8'h57, 8'h00, 8'h06});
		swRead(REG_ADDRESS);
		chk({11'h0, d[4:0]}, 16'h0005);
		swRead(REG_CONFIG);
		chk({14'h0, d[1:0]}, 16'h0000);
		runPkt('{8'h57, 8'h00, 8'h09}, 0, 0, 0, 0);
		chkPkt('{8'h57, 8'h00, 8'h09});
		swWrite(REG_CONFIG, 16'h0003);
		upstackPath <= 1'b0;
		runPkt('{8'h57, 8'h00, 8'h09}, 0, 0, 0, 0);
		chkPkt('{8'h57, 8'h00, 8'h09});
		upstackPath <= 1'b1;
	endtask : tAssign

	// Broadcast write: good check writes, bad check skips yet counts
	task automatic tWrite();
		c = host.crc8('{8'h02, 8'h20, 8'h34, 8'h12});
		runPkt('{8'h02, 8'h20, 8'h34, 8'h12}, 1, 0, 1, 8'hFF);
		chkPkt('{8'h02, 8'h20, 8'h34, 8'h12, c, 8'h00});
		chk(16'(wrCnt), 16'h0001);
		chk(wrWord, 16'h1234);
		chk({8'h00, wrAddr}, 16'h0020);
		runPkt('{8'h02, 8'h20, 8'h34, 8'h12}, 1, 8'h01, 1, 8'h10);
		chkPkt('{8'h02, 8'h20, 8'h34, 8'h12, c ^ 8'h01, 8'h11});
		chk(16'(wrCnt), 16'h0001);
		chk({15'h0, pcAlert}, 16'h0001);
		swRead(REG_STATUS);
		chk({15'h0, d[0]}, 16'h0001);
		// Single writes: the addressed one writes and counts, another address passes
		c = host.crc8('{8'h2C, 8'h21, 8'h78, 8'h56});
		runPkt('{8'h2C, 8'h21, 8'h78, 8'h56}, 1, 0, 1, 8'h30);
		chkPkt('{8'h2C, 8'h21, 8'h78, 8'h56, c, 8'h31});
		chk(wrWord, 16'h5678);
		c = host.crc8('{8'h34, 8'h21, 8'h00, 8'h00});
		runPkt('{8'h34, 8'h21, 8'h00, 8'h00}, 1, 0, 1, 8'h30);
		chkPkt('{8'h34, 8'h21, 8'h00, 8'h00, c, 8'h30});
		chk(16'(wrCnt), 16'h0002);
	endtask : tWrite

	// Reads: addressed, other address, broadcast at first position
	task automatic tRead();
		ovAlert <= 1'b1;
		diagTwo <= 1'b1;
		runPkt('{8'h2D, 8'h10, 8'hC2, 8'hD3, 8'h19}, 1, 0, 1, 8'h07);
		c = host.crc8('{8'h2D, 8'h10, 8'hEF, 8'hBE, 8'hFD});
		chkPkt('{8'h2D, 8'h10, 8'hEF, 8'hBE, 8'hFD, c, 8'h08});
		chk({8'h00, regSelAddr}, 16'h0010);
		c = host.crc8('{8'h35, 8'h10, 8'hC2, 8'hD3, 8'h19});
		runPkt('{8'h35, 8'h10, 8'hC2, 8'hD3, 8'h19}, 1, 0, 1, 8'h07);
		chkPkt('{8'h35, 8'h10, 8'hC2, 8'hD3, 8'h19, c, 8'h07});
		swWrite(REG_ADDRESS, 16'h0500);
		// Clear the check alert so the other summary bits stand alone
		swWrite(REG_STATUS, 16'h0001);
		{ovAlert, diagTwo, diagOne, uvAlert, otherAlert} <= 5'h07;
		// Broadcast read: check and alive come before the fill pair
		c = host.crc8('{8'h03, 8'h10, 8'h00});
		runPkt('{8'h03, 8'h10, 8'h00, c, 8'h20, 8'hC2, 8'hD3}, 0, 0, 0, 0);
		chk({15'h0, pcAlert}, 16'h0000);
		c = host.crc8('{8'h03, 8'h10, 8'hEF, 8'hBE, 8'h62});
		chkPkt('{8'h03, 8'h10, 8'hEF, 8'hBE, 8'h62, c, 8'h21});
	endtask : tRead

	initial begin
		{nrst, upstackPath, ovAlert, diagOne, diagTwo, uvAlert, otherAlert, swWr, swRd, swAddr, swWrData} = '0;
		{wrCnt, errorCnt, samplesChecked} = '0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		upstackPath <= 1'b1;
		tAssign();
		tWrite();
		tRead();
		printVerdict();
	end
endmodule : tb_top
